// File: lbcr_pkg.sv
package lbcr_pkg;

  // Serial slave address, arbitrary value
  localparam logic [6:0] LBCR_DEV_ADDR   = 7'h36;
  localparam logic [3:0] LBCR_BYTE_BITS  = 4'h8;

  // Register offsets
  localparam logic [7:0] OFS_SINK_MAP    = 8'h11;
  localparam logic [7:0] OFS_RAMP_C      = 8'h14;
  localparam logic [7:0] OFS_RAMP_D      = 8'h15;
  localparam logic [7:0] OFS_RAMP_E      = 8'h16;
  localparam logic [7:0] OFS_RAMP_F      = 8'h17;
  localparam logic [7:0] OFS_FS_C        = 8'h22;
  localparam logic [7:0] OFS_FS_F        = 8'h25;
  localparam logic [7:0] OFS_FB_EN       = 8'h29;
  localparam logic [7:0] OFS_BANK_EN     = 8'h2b;
  localparam logic [7:0] OFS_BOOST       = 8'h2d;
  localparam logic [7:0] OFS_PWM         = 8'h2f;
  localparam logic [7:0] OFS_LVL_A_LO    = 8'h40;
  localparam logic [7:0] OFS_LVL_A_HI    = 8'h41;
  localparam logic [7:0] OFS_LVL_C       = 8'h44;
  localparam logic [7:0] OFS_LVL_F       = 8'h47;

  // PWM settings field positions
  localparam int         PWM_ZERO_BIT    = 3;
  localparam int         PWM_POL_BIT     = 2;
  localparam int         PWM_B_BIT       = 1;
  localparam int         PWM_A_BIT       = 0;
  // Bank enable bit positions, A in bit 0 up to H in bit 7
  localparam int         BANK_A_BIT      = 0;
  localparam int         BANK_C_BIT      = 2;
  localparam int         BANK_F_BIT      = 5;
  // Bank A low byte carries the three low level bits
  localparam int         LVL_LO_BITS     = 3;
  localparam int         LVL_BITS        = 11;

  // Reset values
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_RAMP        = 8'h00;   // Code for 2048 us ramps
  localparam logic [7:0] RST_FULL_SCALE  = 8'h00;
  localparam logic       RST_MAP_EXP     = 1'b1;    // Exponential mapping
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100
  } lbcr_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR  = 2'b01,
    PH_DATA = 2'b10
  } lbcr_phase_t;

  // Stored configuration, one field per register
  typedef struct packed {
    logic [7:0]      sink_bank_map;
    logic [3:0][7:0] onoff_ramp;      // Index 0 bank C .. 3 bank F
    logic [7:0]      full_scale_c;
    logic [7:0]      full_scale_f;
    logic [7:0]      feedback_en;
    logic [7:0]      bank_en;
    logic [7:0]      boost;
    logic [7:0]      pwm;
    logic [7:0]      level_a_low;
    logic [7:0]      level_a_high;
    logic [7:0]      level_c;
    logic [7:0]      level_f;
  } lbcr_cfg_t;

  // Open-drain data pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } lbcr_od_t;

endpackage : lbcr_pkg

// File: lbcr_regs.sv
module lbcr_regs
  import lbcr_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output      logic                sda_o,
  output      logic                sda_oe,
  output      lbcr_cfg_t           cfg,
  output      logic [LVL_BITS-1:0] bank_a_level,
  output      logic                map_exponential,
  output      logic                pwm_zero_detect,
  output      logic                pwm_active_high,
  output      logic                pwm_bank_a,
  output      logic                pwm_bank_b
);

  lbcr_cfg_t           cfg_r;
  logic [LVL_BITS-1:0] level_a_r;
  logic                map_exp_r;
  lbcr_od_t            sda_r;
  lbcr_state_t         state_r;
  lbcr_phase_t         phase_r;
  logic [3:0]          cnt_r;
  logic [7:0]          shift_r;
  logic [7:0]          ptr_r;
  logic                rw_r;
  logic                ack_r;
  logic                scl_q;
  logic                sda_q;
  logic [7:0]          rd_data;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                byte_done;
  logic                wr_fire;

  // Previous pin levels for edge and condition detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Bus events; start and stop are data edges while the clock is high
  assign scl_rise  = scl_i & ~scl_q;
  assign scl_fall  = ~scl_i & scl_q;
  assign start_det = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_done = (state_r == ST_RX) && scl_fall && (cnt_r == LBCR_BYTE_BITS);
  // Data byte lands at the falling clock after its eighth bit
  assign wr_fire   = byte_done && (phase_r == PH_DATA);

  // Read-back mux; unmapped offsets read as zero
  always_comb begin
    rd_data = RD_UNMAPPED;
    case (ptr_r)
      OFS_SINK_MAP: rd_data = cfg_r.sink_bank_map;
      OFS_RAMP_C:   rd_data = cfg_r.onoff_ramp[0];
      OFS_RAMP_D:   rd_data = cfg_r.onoff_ramp[1];
      OFS_RAMP_E:   rd_data = cfg_r.onoff_ramp[2];
      OFS_RAMP_F:   rd_data = cfg_r.onoff_ramp[3];
      OFS_FS_C:     rd_data = cfg_r.full_scale_c;
      OFS_FS_F:     rd_data = cfg_r.full_scale_f;
      OFS_FB_EN:    rd_data = cfg_r.feedback_en;
      OFS_BANK_EN:  rd_data = cfg_r.bank_en;
      OFS_BOOST:    rd_data = cfg_r.boost;
      OFS_PWM:      rd_data = cfg_r.pwm;
      OFS_LVL_A_LO: rd_data = cfg_r.level_a_low;
      OFS_LVL_A_HI: rd_data = cfg_r.level_a_high;
      OFS_LVL_C:    rd_data = cfg_r.level_c;
      OFS_LVL_F:    rd_data = cfg_r.level_f;
      default:      rd_data = RD_UNMAPPED;
    endcase
  end

  // Serial link slave: address, pointer, then data bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      phase_r  <= PH_ADDR;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      ack_r    <= 1'b0;
      sda_r.o  <= 1'b0;
      sda_r.oe <= 1'b0;
    end else if (stop_det) begin
      state_r  <= ST_IDLE;
      sda_r.oe <= 1'b0;
    end else if (start_det) begin
      // Repeated start keeps the pointer so a read can follow a pointer write
      state_r  <= ST_RX;
      phase_r  <= PH_ADDR;
      cnt_r    <= 4'h0;
      sda_r.oe <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise && (cnt_r != LBCR_BYTE_BITS)) begin
            shift_r <= {shift_r[6:0], sda_i};
            cnt_r   <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            case (phase_r)
              PH_ADDR: begin
                if (shift_r[7:1] == LBCR_DEV_ADDR) begin
                  rw_r     <= shift_r[0];
                  sda_r.oe <= 1'b1;
                  state_r  <= ST_ACK;
                end else begin
                  // Not our address: stay off the bus until the next start
                  state_r <= ST_IDLE;
                end
              end
              PH_PTR: begin
                ptr_r    <= shift_r;
                sda_r.oe <= 1'b1;
                state_r  <= ST_ACK;
              end
              default: begin
                // Auto-increment lets one transfer fill neighbours
                ptr_r    <= ptr_r + 8'h01;
                sda_r.oe <= 1'b1;
                state_r  <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if ((phase_r == PH_ADDR) && rw_r) begin
              shift_r  <= {rd_data[6:0], 1'b0};
              sda_r.oe <= ~rd_data[7];
              ptr_r    <= ptr_r + 8'h01;
              cnt_r    <= 4'h1;
              state_r  <= ST_TX;
            end else begin
              sda_r.oe <= 1'b0;
              phase_r  <= (phase_r == PH_ADDR) ? PH_PTR : PH_DATA;
              state_r  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == LBCR_BYTE_BITS) begin
              sda_r.oe <= 1'b0;
              cnt_r    <= 4'h0;
              state_r  <= ST_TXACK;
            end else begin
              sda_r.oe <= ~shift_r[7];
              shift_r  <= {shift_r[6:0], 1'b0};
              cnt_r    <= cnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ack_r <= ~sda_i;
          end else if (scl_fall) begin
            if (ack_r) begin
              shift_r  <= {rd_data[6:0], 1'b0};
              sda_r.oe <= ~rd_data[7];
              ptr_r    <= ptr_r + 8'h01;
              cnt_r    <= 4'h1;
              state_r  <= ST_TX;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_r.oe <= 1'b0;
        end
      endcase
    end
  end

  // Register file; unmapped writes are dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r.sink_bank_map <= RST_ZERO;
      cfg_r.onoff_ramp    <= {4{RST_RAMP}};
      cfg_r.full_scale_c  <= RST_FULL_SCALE;
      cfg_r.full_scale_f  <= RST_FULL_SCALE;
      cfg_r.feedback_en   <= RST_ZERO;
      cfg_r.bank_en       <= RST_ZERO;
      cfg_r.boost         <= RST_ZERO;
      cfg_r.pwm           <= RST_ZERO;
      cfg_r.level_a_low   <= RST_ZERO;
      cfg_r.level_a_high  <= RST_ZERO;
      cfg_r.level_c       <= RST_ZERO;
      cfg_r.level_f       <= RST_ZERO;
    end else if (wr_fire) begin
      case (ptr_r)
        // Map code decides sink grouping, e.g. 0x20 or 0x36
        OFS_SINK_MAP: cfg_r.sink_bank_map  <= shift_r;
        // Ramp code 0x33 means 1.049 s up and down
        OFS_RAMP_C:   cfg_r.onoff_ramp[0]  <= shift_r;
        OFS_RAMP_D:   cfg_r.onoff_ramp[1]  <= shift_r;
        OFS_RAMP_E:   cfg_r.onoff_ramp[2]  <= shift_r;
        OFS_RAMP_F:   cfg_r.onoff_ramp[3]  <= shift_r;
        // Code 0x00 is the 5 mA full scale
        OFS_FS_C:     cfg_r.full_scale_c   <= shift_r;
        OFS_FS_F:     cfg_r.full_scale_f   <= shift_r;
        // Bit n-1 enables feedback on sink n
        OFS_FB_EN:    cfg_r.feedback_en    <= shift_r;
        // Shared by high-voltage and indicator banks
        OFS_BANK_EN:  cfg_r.bank_en        <= shift_r;
        OFS_BOOST:    cfg_r.boost          <= shift_r;
        OFS_PWM:      cfg_r.pwm            <= shift_r;
        // Low byte only parks here until the high byte arrives
        OFS_LVL_A_LO: cfg_r.level_a_low    <= shift_r;
        OFS_LVL_A_HI: cfg_r.level_a_high   <= shift_r;
        // Indicator banks C and F each have their own level register
        OFS_LVL_C:    cfg_r.level_c        <= shift_r;
        OFS_LVL_F:    cfg_r.level_f        <= shift_r;
        default:      cfg_r.sink_bank_map  <= cfg_r.sink_bank_map;
      endcase
    end
  end

  // Applied bank A level: high byte write commits the parked low bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_a_r <= {LVL_BITS{1'b0}};
    end else if (wr_fire && (ptr_r == OFS_LVL_A_HI)) begin
      level_a_r <= {shift_r, cfg_r.level_a_low[LVL_LO_BITS-1:0]};
    end
  end

  // Mapping mode has no register here; it holds its reset choice
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_exp_r <= RST_MAP_EXP;
    end else begin
      map_exp_r <= map_exp_r;
    end
  end

  // Outputs straight from the flops
  assign sda_o           = sda_r.o;
  assign sda_oe          = sda_r.oe;
  assign cfg             = cfg_r;
  assign bank_a_level    = level_a_r;
  assign map_exponential = map_exp_r;
  // 0x0D sets zero detect, active high, bank A on, bank B off
  assign pwm_zero_detect = cfg_r.pwm[PWM_ZERO_BIT];
  assign pwm_active_high = cfg_r.pwm[PWM_POL_BIT];
  assign pwm_bank_b      = cfg_r.pwm[PWM_B_BIT];
  assign pwm_bank_a      = cfg_r.pwm[PWM_A_BIT];

endmodule : lbcr_regs

// File: lbcr_assertions.sv
module lbcr_assertions
  import lbcr_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                scl_i,
  input wire logic                sda_i,
  input wire logic                sda_o,
  input wire logic                sda_oe,
  input wire lbcr_cfg_t           cfg,
  input wire logic [LVL_BITS-1:0] bank_a_level,
  input wire logic                map_exponential,
  input wire logic                pwm_zero_detect,
  input wire logic                pwm_active_high,
  input wire logic                pwm_bank_a,
  input wire logic                pwm_bank_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Level the bank A output should show once the high byte lands
  logic [LVL_BITS-1:0] level_exp;
  assign level_exp = {cfg.level_a_high, cfg.level_a_low[LVL_LO_BITS-1:0]};
  // Pin moves settle one core clock after the serial clock fell
  sequence s_after_fall;
    $past(scl_i, 2) && !$past(scl_i);
  endsequence
  a_oe_after_fall: assert property ($changed(sda_oe) |-> s_after_fall)
    else $error("data drive moved away from a clock fall");
  a_cfg_with_ack: assert property ($changed(cfg) |-> $rose(sda_oe) ##0 s_after_fall)
    else $error("register changed without its acknowledge");
  a_low_pending: assert property ($changed(cfg.level_a_low) |-> $stable(bank_a_level))
    else $error("low byte applied without a high byte write");
  a_high_applies: assert property ($changed(cfg.level_a_high) |-> bank_a_level == level_exp)
    else $error("high byte write did not apply the level");
  a_level_source: assert property ($changed(bank_a_level) |-> $rose(sda_oe) && bank_a_level == level_exp)
    else $error("bank A level moved outside a write");
  a_pwm_fields: assert property ($changed(cfg.pwm) |-> ##[0:1]
    {pwm_zero_detect, pwm_active_high, pwm_bank_b, pwm_bank_a} == cfg.pwm[PWM_ZERO_BIT:PWM_A_BIT])
    else $error("pwm outputs disagree with pwm settings");
  a_map_fixed: assert property (map_exponential == RST_MAP_EXP)
    else $error("mapping left exponential");
  a_reset_state: assert property ($rose(rst_n) |-> cfg.onoff_ramp == {4{RST_RAMP}} && bank_a_level == '0)
    else $error("ramp or level not at default after reset");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data pin would be driven high");
endmodule : lbcr_assertions

// File: lbcr_host.sv
module lbcr_host
  import lbcr_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sda_line,
  output      logic scl,
  output      logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ack_seen;
  logic [7:0] rd_byte;
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    ack_seen = 1'b0;
  end
  // Four clocks a phase keeps each level well past two samples
  task automatic hold();
    repeat (4) @(negedge core_clk);
  endtask : hold
  // Data moves only while scl is low; a 1 merely releases the line
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    hold();
    scl = 1'b1;
    hold();
    s = sda_line;
    scl = 1'b0;
    hold();
  endtask : bit_io
  // Start and stop are data edges with the clock high
  task automatic start();
    sda_pull = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b1;
    hold();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b0;
    hold();
  endtask : stop
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] v, input logic last, output logic [7:0] got);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
      got[i] = s;
    end
    bit_io(last, s);
    ack_seen = ~s;
  endtask : xfer
  // Pointer write, then one data byte or a repeated-start read of one byte
  task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat, input logic rd);
    logic [7:0] g;
    start();
    xfer({dev, 1'b0}, 1'b1, g);
    xfer(ptr, 1'b1, g);
    if (rd) begin
      start();
      xfer({dev, 1'b1}, 1'b1, g);
      xfer(8'hff, 1'b1, rd_byte);
    end else begin
      xfer(dat, 1'b1, g);
    end
    stop();
  endtask : access
endmodule : lbcr_host

// File: lbcr_tb.sv
module testbench
  import lbcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0]  sel;
    logic [15:0] val;
  } lbcr_note_t;
  logic                core_clk;
  logic                rst_n;
  logic                scl;
  logic                sda_pull;
  logic                sda_oe;
  logic                smp;
  logic [7:0]          r;
  logic [7:0]          hi;
  logic [7:0]          lo;
  logic [15:0]         seen;
  logic [LVL_BITS-1:0] bank_a_level;
  logic [3:0]          pwm;
  logic                map_exponential;
  integer              seed;
  int                  n_mismatch;
  int                  cmp_count;
  lbcr_note_t          note;
  lbcr_note_t          note_q[$];
  wire                 sda_line = ~(sda_pull | sda_oe);
  string               what[5] = '{"read_byte", "bank_a_level", "pwm_bits", "map_mode", "ack"};
  logic [15:0]         doc[16] = '{16'h1120, 16'h1136, 16'h291f, 16'h2200, 16'h2500, 16'h1433, 16'h1533, 16'h1633,
                                   16'h1733, 16'h2d03, 16'h2f0d, 16'h44a5, 16'h475a, 16'h2b01, 16'h2b25, 16'h12c3};
  lbcr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe),
    .cfg(), .bank_a_level(bank_a_level), .map_exponential(map_exponential), .pwm_zero_detect(pwm[3]),
    .pwm_active_high(pwm[2]), .pwm_bank_b(pwm[1]), .pwm_bank_a(pwm[0]));
  lbcr_host host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [2:0] sel, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what[sel], exp, got);
    end
  endtask : check
  // Note an expectation; the monitor samples at the next rising edge
  task automatic note_exp(input logic [2:0] sel, input logic [15:0] val);
    note_q.push_back({sel, val});
    smp = 1'b1;
    @(negedge core_clk);
    smp = 1'b0;
    @(negedge core_clk);
  endtask : note_exp
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    host.access(LBCR_DEV_ADDR, ptr, dat, 1'b0);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    host.access(LBCR_DEV_ADDR, ptr, 8'h00, 1'b1);
    note_exp(3'd0, {8'h00, exp});
  endtask : rd_chk
  // Monitor: oldest note against what the outputs show now
  always @(posedge core_clk) begin
    if (smp === 1'b1) begin
      note = note_q.pop_front();
      case (note.sel)
        3'd0: seen = {8'h00, host.rd_byte};
        3'd1: seen = {5'h00, bank_a_level};
        3'd2: seen = {12'h000, pwm};
        3'd3: seen = {15'h0000, map_exponential};
        default: seen = {15'h0000, host.ack_seen};
      endcase
      check(note.sel, note.val, seen);
    end
  end
  // Hang guard well above the longest run
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
  // Main sequence
  initial begin
    seed = 94814;
    rst_n = 1'b0;
    smp = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    note_exp(3'd3, 16'h0001);
    for (int i = 0; i < 4; i++) rd_chk(8'(OFS_RAMP_C + i), RST_RAMP);
    // Random then documented value per offset; levels go before bank enables, last entry unmapped
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed));
      wr(doc[i][15:8], r);
      rd_chk(doc[i][15:8], i == 15 ? RD_UNMAPPED : r);
      wr(doc[i][15:8], doc[i][7:0]);
      note_exp(3'd4, 16'h0001);
      rd_chk(doc[i][15:8], i == 15 ? RD_UNMAPPED : doc[i][7:0]);
    end
    note_exp(3'd2, 16'h000d);
    lo = 8'($random(seed)) | 8'h05;
    hi = 8'($random(seed));
    wr(OFS_LVL_A_LO, lo);
    note_exp(3'd1, 16'h0000);
    wr(OFS_LVL_A_HI, hi);
    note_exp(3'd1, {5'h00, hi, lo[2:0]});
    r = lo ^ 8'h07;
    wr(OFS_LVL_A_LO, r);
    rd_chk(OFS_LVL_A_LO, r);
    note_exp(3'd1, {5'h00, hi, lo[2:0]});
    wr(OFS_LVL_A_HI, hi);
    note_exp(3'd1, {5'h00, hi, r[2:0]});
    // Foreign device address must be ignored
    host.access(LBCR_DEV_ADDR ^ 7'h01, OFS_PWM, 8'h00, 1'b0);
    note_exp(3'd4, 16'h0000);
    note_exp(3'd2, 16'h000d);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    note_exp(3'd1, 16'h0000);
    rd_chk(OFS_RAMP_F, RST_RAMP);
    complete_run();
  end
endmodule : testbench
bind lbcr_regs lbcr_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg), .bank_a_level(bank_a_level), .map_exponential(map_exponential),
  .pwm_zero_detect(pwm_zero_detect), .pwm_active_high(pwm_active_high), .pwm_bank_a(pwm_bank_a),
  .pwm_bank_b(pwm_bank_b));
